// ==== timer8_pkg.sv ====
/*
 * Constants and carrier types of the eight-bit waveform timer.
 * Assumes one clock, the CPU clock, drives every user of this package.
 */
package timer8_pkg;

	// ----------------------------------------------------------------
	// Counter, capture and compare values
	// ----------------------------------------------------------------
	localparam logic [7:0] COUNT_RESET = 8'h00;
	localparam logic [7:0] TRIGGER_LOAD = 8'hFC;
	localparam logic [15:0] PULSE_CAPTURE_LOAD = 16'hFFFD;
	localparam logic [7:0] COMPARE_RESET = 8'h00;

	// ----------------------------------------------------------------
	// Tick divider
	// ----------------------------------------------------------------
	localparam int DIVIDER_WIDTH = 13;
	localparam logic [1:0] TICK_DIV4_CODE = 2'h0;
	localparam logic [1:0] TICK_DIV2_CODE = 2'h1;
	localparam logic [1:0] TICK_DIV8_CODE = 2'h2;
	localparam logic [12:0] TICK_DIV4 = 13'h0004;
	localparam logic [12:0] TICK_DIV2 = 13'h0002;
	localparam logic [12:0] TICK_DIV8 = 13'h0008;
	localparam int TICK_SLOW_DIV = 8000;

	// ----------------------------------------------------------------
	// Flag positions
	// ----------------------------------------------------------------
	localparam int FLAG_COUNT = 4;
	localparam int FLAG_CAP1 = 0;
	localparam int FLAG_CAP2 = 1;
	localparam int FLAG_CMP1 = 2;
	localparam int FLAG_CMP2 = 3;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [2:0]
	{
		MODE_FREE = 3'b001,
		MODE_SINGLE = 3'b010,
		MODE_PWM = 3'b100
	} mode_t;

	typedef struct packed
	{
		logic capture_irq_enable;
		logic compare_irq_enable;
		logic after_pulse_level;
		logic during_pulse_level;
		logic trigger_edge_select;
		logic capture_edge_select_2;
		logic wave_pin_enable_1;
		logic single_pulse_select;
		logic pwm_select;
		logic [1:0] tick_divider_select;
	} timer_ctrl_t;

endpackage

// ==== eight_bit_timer.sv ====
/*
 * Eight-bit timer with single-pulse and PWM waveform modes, four event
 * flags with two-step clearing, and HALT freeze with capture arming.
 * Assumes software accesses arrive as one-cycle strobes on clk, and that
 * the pins trigger_in_1 and capture_in_2 are asynchronous to clk.
 */
module eight_bit_timer
	import timer8_pkg::*;
#(
	parameter int SLOW_DIVIDE = TICK_SLOW_DIV
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Configuration
	input timer_ctrl_t ctrl,
	input wire logic irq_mask_global,
	// Software access strobes
	input wire logic flags_read,
	input wire logic capture_access_1,
	input wire logic capture_access_2,
	input wire logic compare_access_1,
	input wire logic compare_access_2,
	input wire logic compare_write_1,
	input wire logic compare_write_2,
	input wire logic [7:0] compare_wdata,
	// Power management
	input wire logic halt_mode,
	input wire logic halt_exit_irq,
	// Pins
	input wire logic trigger_in_1,
	input wire logic capture_in_2,
	output logic wave_out_1,
	output logic wave_out_1_oe,
	// Status
	output logic [FLAG_COUNT-1:0] flags,
	output logic [7:0] counter_value,
	output logic [7:0] capture_value_1,
	output logic [7:0] capture_value_2,
	output logic [7:0] compare_value_1,
	output logic [7:0] compare_value_2,
	output logic timer_irq,
	output logic wake_request
);

	// ----------------------------------------------------------------
	// Pin synchronisers and edge detection
	// ----------------------------------------------------------------
	logic [1:0] trig_sync_reg;
	logic [1:0] cap2_sync_reg;
	logic trig_prev_reg;
	logic cap2_prev_reg;
	logic trig_edge;
	logic cap2_edge;

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			trig_sync_reg <= 2'h0;
			cap2_sync_reg <= 2'h0;
			trig_prev_reg <= 1'b0;
			cap2_prev_reg <= 1'b0;
		end
		else
		begin
			trig_sync_reg <= {trig_sync_reg[0], trigger_in_1};
			cap2_sync_reg <= {cap2_sync_reg[0], capture_in_2};
			trig_prev_reg <= trig_sync_reg[1];
			cap2_prev_reg <= cap2_sync_reg[1];
		end
	end

	assign trig_edge = ctrl.trigger_edge_select ? (trig_sync_reg[1] & ~trig_prev_reg)
		: (~trig_sync_reg[1] & trig_prev_reg);
	assign cap2_edge = ctrl.capture_edge_select_2 ? (cap2_sync_reg[1] & ~cap2_prev_reg)
		: (~cap2_sync_reg[1] & cap2_prev_reg);

	// ----------------------------------------------------------------
	// Mode selection
	// ----------------------------------------------------------------
	mode_t mode_reg;
	mode_t mode_next;

	always_comb
	begin
		case ({ctrl.pwm_select, ctrl.single_pulse_select})
			2'b10, 2'b11: mode_next = MODE_PWM;
			2'b01: mode_next = MODE_SINGLE;
			default: mode_next = MODE_FREE;
		endcase
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			mode_reg <= MODE_FREE;
		else
			mode_reg <= mode_next;
	end

	// ----------------------------------------------------------------
	// Tick divider
	// ----------------------------------------------------------------
	localparam logic [DIVIDER_WIDTH-1:0] SLOW_LIMIT = DIVIDER_WIDTH'(SLOW_DIVIDE);
	logic [DIVIDER_WIDTH-1:0] div_reg;
	logic [DIVIDER_WIDTH-1:0] div_limit;
	logic tick;

	always_comb
	begin
		case (ctrl.tick_divider_select)
			TICK_DIV4_CODE: div_limit = TICK_DIV4;
			TICK_DIV2_CODE: div_limit = TICK_DIV2;
			TICK_DIV8_CODE: div_limit = TICK_DIV8;
			default: div_limit = SLOW_LIMIT;
		endcase
	end

	// The divider stops with the counter in HALT so a wake resumes mid-tick.
	assign tick = ~halt_mode && (div_reg >= div_limit - 1'b1);

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			div_reg <= '0;
		else if (halt_mode)
			div_reg <= div_reg;
		else if (tick)
			div_reg <= '0;
		else
			div_reg <= div_reg + 1'b1;
	end

	// ----------------------------------------------------------------
	// Counter and compare matching
	// ----------------------------------------------------------------
	logic [7:0] count_reg;
	logic [7:0] cmp_written_reg [2];
	logic [7:0] cmp_active_reg [2];
	logic pulse_trigger;
	logic match_1;
	logic match_2;

	assign pulse_trigger = (mode_reg == MODE_SINGLE) && trig_edge && ~halt_mode;
	assign match_1 = tick && (count_reg == cmp_active_reg[0]);
	assign match_2 = tick && (count_reg == cmp_active_reg[1]);

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			count_reg <= COUNT_RESET;
		else if (pulse_trigger)
			count_reg <= TRIGGER_LOAD;
		else if (mode_reg == MODE_PWM && match_2)
			count_reg <= TRIGGER_LOAD;
		else if (tick)
			count_reg <= count_reg + 1'b1;
	end

	// Outside PWM the working copy simply follows the written value.
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			cmp_written_reg[0] <= COMPARE_RESET;
			cmp_written_reg[1] <= COMPARE_RESET;
			cmp_active_reg[0] <= COMPARE_RESET;
			cmp_active_reg[1] <= COMPARE_RESET;
		end
		else
		begin
			if (compare_write_1)
				cmp_written_reg[0] <= compare_wdata;
			if (compare_write_2)
				cmp_written_reg[1] <= compare_wdata;
			if (mode_reg != MODE_PWM || match_2)
			begin
				cmp_active_reg[0] <= cmp_written_reg[0];
				cmp_active_reg[1] <= cmp_written_reg[1];
			end
		end
	end

	// ----------------------------------------------------------------
	// Waveform output
	// ----------------------------------------------------------------
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			wave_out_1 <= 1'b0;
		else
		begin
			case (mode_reg)
				MODE_SINGLE:
				begin
					if (pulse_trigger)
						wave_out_1 <= ctrl.during_pulse_level;
					else if (match_1)
						wave_out_1 <= ctrl.after_pulse_level;
				end
				MODE_PWM:
				begin
					// Match 2 wins a tie so the period boundary always lands.
					if (match_2)
						wave_out_1 <= ctrl.during_pulse_level;
					else if (match_1)
						wave_out_1 <= ctrl.after_pulse_level;
				end
				MODE_FREE:
				begin
					if (match_1)
						wave_out_1 <= ctrl.after_pulse_level;
				end
				default: wave_out_1 <= 1'b0;
			endcase
		end
	end

	assign wave_out_1_oe = ctrl.wave_pin_enable_1;

	// ----------------------------------------------------------------
	// Captures, HALT arming and flags
	// ----------------------------------------------------------------
	logic [1:0] halt_armed_reg;
	logic [FLAG_COUNT-1:0] flag_reg;
	logic [FLAG_COUNT-1:0] clr_armed_reg;
	logic [FLAG_COUNT-1:0] flag_set;
	logic [FLAG_COUNT-1:0] reg_access;
	logic [7:0] cap1_reg;
	logic [7:0] cap2_reg;
	logic free_cap1;
	logic wake_cap1;
	logic wake_cap2;

	assign free_cap1 = (mode_reg == MODE_FREE) && trig_edge && ~halt_mode;
	assign wake_cap1 = halt_exit_irq && halt_armed_reg[0];
	assign wake_cap2 = halt_exit_irq && halt_armed_reg[1];

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			halt_armed_reg <= 2'h0;
		else if (halt_exit_irq)
			halt_armed_reg <= 2'h0;
		else if (halt_mode)
			halt_armed_reg <= halt_armed_reg | {cap2_edge, trig_edge && mode_reg == MODE_FREE};
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			cap1_reg <= COUNT_RESET;
			cap2_reg <= COUNT_RESET;
		end
		else
		begin
			if (pulse_trigger)
				cap1_reg <= PULSE_CAPTURE_LOAD[7:0];
			else if (free_cap1 || wake_cap1)
				cap1_reg <= count_reg;
			if ((cap2_edge && ~halt_mode) || wake_cap2)
				cap2_reg <= count_reg;
		end
	end

	always_comb
	begin
		flag_set[FLAG_CAP1] = free_cap1 || wake_cap1 || pulse_trigger
			|| (mode_reg == MODE_PWM && match_2);
		flag_set[FLAG_CAP2] = (cap2_edge && ~halt_mode) || wake_cap2;
		flag_set[FLAG_CMP1] = match_1 && mode_reg == MODE_FREE;
		flag_set[FLAG_CMP2] = match_2 && mode_reg != MODE_PWM;
	end

	assign reg_access = {compare_access_2, compare_access_1, capture_access_2, capture_access_1};

	// A new event in the clearing cycle keeps its flag set.
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			flag_reg <= '0;
			clr_armed_reg <= '0;
		end
		else
		begin
			for (int i = 0; i < FLAG_COUNT; i++)
			begin
				flag_reg[i] <= flag_set[i] || (flag_reg[i] && !(reg_access[i] && clr_armed_reg[i]));
				if (reg_access[i])
					clr_armed_reg[i] <= 1'b0;
				else if (flags_read && flag_reg[i])
					clr_armed_reg[i] <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Outputs and interrupt request
	// ----------------------------------------------------------------
	assign flags = flag_reg;
	assign counter_value = count_reg;
	assign capture_value_1 = cap1_reg;
	assign capture_value_2 = cap2_reg;
	assign compare_value_1 = cmp_written_reg[0];
	assign compare_value_2 = cmp_written_reg[1];
	assign timer_irq = ~irq_mask_global
		&& ((ctrl.capture_irq_enable && (flag_reg[FLAG_CAP1] || flag_reg[FLAG_CAP2]))
		|| (ctrl.compare_irq_enable && (flag_reg[FLAG_CMP1] || flag_reg[FLAG_CMP2])));
	assign wake_request = timer_irq;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	trigger_load_a: assert property (pulse_trigger |=> count_reg == TRIGGER_LOAD
		&& flag_reg[FLAG_CAP1] && cap1_reg == PULSE_CAPTURE_LOAD[7:0]
		&& wave_out_1 == $past(ctrl.during_pulse_level))
		else $error("trigger edge did not start the pulse");
	pulse_end_a: assert property (mode_reg == MODE_SINGLE && match_1 && !pulse_trigger
		|=> wave_out_1 == $past(ctrl.after_pulse_level))
		else $error("compare 1 match did not end the pulse");
	single_no_cmp1_a: assert property (mode_reg == MODE_SINGLE && !flag_reg[FLAG_CMP1]
		|=> !flag_reg[FLAG_CMP1])
		else $error("compare flag 1 set in single-pulse mode");
	pwm_priority_a: assert property ($past(ctrl.pwm_select) |-> mode_reg == MODE_PWM)
		else $error("pwm select did not win");
	pwm_no_cmp_a: assert property (mode_reg == MODE_PWM && flag_reg[3:2] == 2'h0
		|=> flag_reg[3:2] == 2'h0)
		else $error("compare flag set in pwm mode");
	pwm_reload_a: assert property (mode_reg == MODE_PWM && match_2 && !pulse_trigger
		|=> count_reg == TRIGGER_LOAD && flag_reg[FLAG_CAP1])
		else $error("period end did not reload counter");
	halt_freeze_a: assert property (halt_mode |=> count_reg == $past(count_reg))
		else $error("counter moved in halt");
	clear_order_a: assert property (flag_reg[FLAG_CAP1] && !clr_armed_reg[FLAG_CAP1]
		|=> flag_reg[FLAG_CAP1])
		else $error("capture flag cleared without a status read");
	irq_gate_a: assert property (flag_reg[FLAG_CAP1] && ctrl.capture_irq_enable
		&& !irq_mask_global |-> timer_irq ##0 wake_request)
		else $error("capture flag did not request interrupt");
	tick_spacing_a: assert property (tick |=> !tick)
		else $error("ticks closer than two clocks");

	pulse_seen_c: cover property (pulse_trigger ##[1:300] (mode_reg == MODE_SINGLE && match_1));
	pwm_period_c: cover property (mode_reg == MODE_PWM && match_1 ##[1:300] match_2);
	halt_wake_c: cover property (halt_mode && cap2_edge ##[1:50] halt_exit_irq);
	flag_clear_c: cover property (clr_armed_reg[FLAG_CAP1] && capture_access_1);

endmodule

// ==== pin_source.sv ====
/*
 * Behavioural source for the trigger pin and the second capture pin.
 * Assumes one-cycle request strobes on clk and a level edge select per pin.
 */
module pin_source (
	// Clock
	input wire logic clk,
	// Requests
	input wire logic fire_trig,
	input wire logic fire_cap,
	input wire logic edge_trig,
	input wire logic edge_cap,
	// Pins
	output logic trigger_in_1,
	output logic capture_in_2
);
	timeunit 1ns;
	timeprecision 100ps;

	logic [2:0] hold_trig = 3'h0;
	logic [2:0] hold_cap = 3'h0;

	// A pin rests at the inverse of its active edge. Changing the edge select therefore
	// only ever makes an inactive edge, and the return to rest is an inactive edge too.
	always @(posedge clk)
	begin
		if (fire_trig)
			hold_trig <= 3'h6;
		else if (hold_trig != 3'h0)
			hold_trig <= hold_trig - 3'h1;
		if (fire_cap)
			hold_cap <= 3'h6;
		else if (hold_cap != 3'h0)
			hold_cap <= hold_cap - 3'h1;
	end

	assign trigger_in_1 = (hold_trig != 3'h0) ? edge_trig : ~edge_trig;
	assign capture_in_2 = (hold_cap != 3'h0) ? edge_cap : ~edge_cap;
endmodule

// ==== timer8_one_pulse_pwm_modes_tb_top.sv ====
/*
 * Self-checking bench for the eight-bit waveform timer.
 * Assumes the pin source model drives both capture pins.
 */
module timer8_one_pulse_pwm_modes_tb_top import timer8_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;

	logic clk = 1'b0;
	logic reset = 1'b1;
	timer_ctrl_t ctrl = '0;
	logic irq_mask_global = 1'b0;
	logic flags_read = 1'b0;
	logic capture_access_1 = 1'b0;
	logic capture_access_2 = 1'b0;
	logic compare_access_1 = 1'b0;
	logic compare_access_2 = 1'b0;
	logic compare_write_1 = 1'b0;
	logic compare_write_2 = 1'b0;
	logic [7:0] compare_wdata = 8'h00;
	logic halt_mode = 1'b0;
	logic halt_exit_irq = 1'b0;
	logic fire_trig = 1'b0;
	logic fire_cap = 1'b0;
	logic trigger_in_1, capture_in_2, wave_out_1, wave_out_1_oe, timer_irq, wake_request;
	logic [3:0] flags;
	logic [7:0] counter_value, capture_value_1, capture_value_2, compare_value_1, compare_value_2;
	logic [7:0] saved;
	int errors = 0;
	int samples_checked = 0;
	int cycles = 0;
	int hi, lo, n;
	// Divider code in bits 13:12, expected clocks per count in the low byte.
	logic [15:0] rows [4] = '{16'h0004, 16'h1002, 16'h2008, 16'h300a};

	eight_bit_timer #(.SLOW_DIVIDE(10)) dut (.clk(clk), .reset(reset), .ctrl(ctrl),
		.irq_mask_global(irq_mask_global), .flags_read(flags_read), .capture_access_1(capture_access_1),
		.capture_access_2(capture_access_2), .compare_access_1(compare_access_1),
		.compare_access_2(compare_access_2), .compare_write_1(compare_write_1),
		.compare_write_2(compare_write_2), .compare_wdata(compare_wdata), .halt_mode(halt_mode),
		.halt_exit_irq(halt_exit_irq), .trigger_in_1(trigger_in_1), .capture_in_2(capture_in_2),
		.wave_out_1(wave_out_1), .wave_out_1_oe(wave_out_1_oe), .flags(flags), .counter_value(counter_value),
		.capture_value_1(capture_value_1), .capture_value_2(capture_value_2),
		.compare_value_1(compare_value_1), .compare_value_2(compare_value_2), .timer_irq(timer_irq),
		.wake_request(wake_request));

	pin_source src (.clk(clk), .fire_trig(fire_trig), .fire_cap(fire_cap), .edge_trig(ctrl.trigger_edge_select),
		.edge_cap(ctrl.capture_edge_select_2), .trigger_in_1(trigger_in_1), .capture_in_2(capture_in_2));

	initial
	begin
		forever #2 clk = ~clk;
	end

	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			errors++;
			finish_test();
		end
	end

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic tick(int k = 1);
		repeat (k) @(posedge clk);
		#1;
	endtask

	task automatic chk_bit(logic got, logic exp);
		samples_checked++;
		if (got !== exp)
		begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_byte(logic [7:0] got, logic [7:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Ends with a spare cycle so a following strobe never lands in the same time step.
	task automatic pulse(ref logic s);
		s = 1'b1;
		tick();
		s = 1'b0;
		tick();
	endtask

	task automatic wait_flag(int i, int lim);
		n = 0;
		while (flags[i] !== 1'b1 && n < lim)
		begin
			tick();
			n++;
		end
	endtask

	task automatic wait_wave(logic lvl, int lim);
		n = 0;
		while (wave_out_1 !== lvl && n < lim)
		begin
			tick();
			n++;
		end
	endtask

	task automatic wait_count();
		saved = counter_value;
		n = 0;
		while (counter_value === saved && n < 40)
		begin
			tick();
			n++;
		end
	endtask

	// Entering PWM, the first period ends only at the stale compare 2 value, up to 256 ticks away.
	task automatic measure();
		wait_wave(1'b0, 600);
		wait_wave(1'b1, 600);
		hi = 0;
		while (wave_out_1 === 1'b1 && hi < 100)
		begin
			tick();
			hi++;
		end
		lo = 0;
		while (wave_out_1 === 1'b0 && lo < 100)
		begin
			tick();
			lo++;
		end
	endtask

	task automatic finish_test();
		if (errors == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Sequence
	// ----------------------------------------------------------------
	initial
	begin
		repeat (12) @(posedge clk);
		#1;
		chk_bit(wave_out_1, 1'b0);
		chk_byte({4'h0, flags}, 8'h00);
		chk_bit(wave_out_1_oe, 1'b0);
		reset = 1'b0;
		tick(2);
		for (int i = 0; i < 4; i++)
		begin
			ctrl.tick_divider_select = rows[i][13:12];
			tick(2);
			wait_count();
			wait_count();
			chk_byte(8'(n), rows[i][7:0]);
		end
		ctrl.tick_divider_select = 2'h1;
		compare_wdata = 8'h02;
		pulse(compare_write_1);
		chk_byte(compare_value_1, 8'h02);
		compare_wdata = 8'h01;
		pulse(compare_write_2);
		chk_byte(compare_value_2, 8'h01);
		ctrl.capture_irq_enable = 1'b1;
		ctrl.during_pulse_level = 1'b1;
		ctrl.trigger_edge_select = 1'b1;
		ctrl.wave_pin_enable_1 = 1'b1;
		ctrl.single_pulse_select = 1'b1;
		pulse(flags_read);
		pulse(compare_access_1);
		chk_bit(wave_out_1_oe, 1'b1);
		pulse(fire_trig);
		wait_flag(0, 20);
		chk_byte(counter_value, 8'hfc);
		chk_byte(capture_value_1, 8'hfd);
		chk_bit(wave_out_1, 1'b1);
		chk_bit(timer_irq, 1'b1);
		chk_bit(wake_request, 1'b1);
		pulse(capture_access_1);
		chk_bit(flags[0], 1'b1);
		pulse(flags_read);
		pulse(compare_access_2);
		wait_wave(1'b0, 40);
		chk_byte(counter_value, 8'h03);
		chk_bit(flags[2], 1'b0);
		chk_bit(flags[3], 1'b1);
		irq_mask_global = 1'b1;
		tick();
		chk_bit(timer_irq, 1'b0);
		irq_mask_global = 1'b0;
		pulse(capture_access_1);
		chk_bit(flags[0], 1'b0);
		ctrl.after_pulse_level = 1'b1;
		ctrl.trigger_edge_select = 1'b0;
		tick(4);
		pulse(fire_trig);
		wait_flag(0, 20);
		chk_bit(flags[0], 1'b1);
		n = 0;
		repeat (40)
		begin
			tick();
			n += (wave_out_1 !== 1'b1);
		end
		chk_byte(8'(n), 8'h00);
		ctrl.capture_edge_select_2 = 1'b1;
		tick(4);
		pulse(fire_cap);
		wait_flag(1, 20);
		chk_bit(flags[1], 1'b1);
		ctrl.after_pulse_level = 1'b1;
		ctrl.during_pulse_level = 1'b0;
		ctrl.pwm_select = 1'b1;
		compare_wdata = 8'h06;
		pulse(compare_write_2);
		chk_byte(compare_value_2, 8'h06);
		pulse(flags_read);
		pulse(capture_access_1);
		pulse(compare_access_2);
		saved = capture_value_1;
		pulse(fire_trig);
		measure();
		measure();
		chk_byte(8'(hi), 8'h08);
		chk_byte(8'(lo), 8'h0e);
		chk_byte(capture_value_1, saved);
		chk_bit(flags[0], 1'b1);
		chk_byte({6'h00, flags[3:2]}, 8'h00);
		wait_wave(1'b1, 40);
		wait_wave(1'b0, 40);
		compare_wdata = 8'h04;
		pulse(compare_write_1);
		chk_byte(compare_value_1, 8'h04);
		measure();
		chk_byte(8'(hi), 8'h08);
		measure();
		chk_byte(8'(hi), 8'h04);
		ctrl.pwm_select = 1'b0;
		ctrl.single_pulse_select = 1'b0;
		pulse(flags_read);
		pulse(capture_access_2);
		halt_mode = 1'b1;
		tick(2);
		saved = counter_value;
		pulse(fire_cap);
		tick(10);
		chk_byte(counter_value, saved);
		chk_bit(flags[1], 1'b0);
		halt_exit_irq = 1'b1;
		halt_mode = 1'b0;
		tick();
		halt_exit_irq = 1'b0;
		tick();
		chk_bit(flags[1], 1'b1);
		chk_byte(capture_value_2, saved);
		tick(8);
		n = 8'(counter_value - saved);
		chk_bit(n >= 3 && n <= 7, 1'b1);
		reset = 1'b1;
		tick();
		chk_byte(counter_value, 8'h00);
		chk_bit(wave_out_1, 1'b0);
		finish_test();
	end
endmodule
